// >>> core/lmccr_pkg.sv
/*
  Constants shared by the LED matrix common configuration register bank:
  serial command codes, field positions, reset values and write masks.
  Assumes a 48-bit register word and a 16-bit command word on the link.
*/
package lmccr_pkg;

  // frame shape on the serial link
  localparam int unsigned CMD_BITS = 16;
  localparam int unsigned DATA_BITS = 48;

  // command codes
  localparam logic [15:0] CMD_WR_A = 16'haa00;
  localparam logic [15:0] CMD_WR_B = 16'haa01;
  localparam logic [15:0] CMD_WR_C = 16'haa02;
  localparam logic [15:0] CMD_RD_A = 16'haa60;
  localparam logic [15:0] CMD_RD_B = 16'haa61;
  localparam logic [15:0] CMD_RD_C = 16'haa62;
  localparam logic [15:0] CMD_SOFT_RESET = 16'haa80;

  // reset values, reserved bits included
  localparam logic [47:0] RST_A = 48'h2000_e000_0107;
  localparam logic [47:0] RST_B = 48'h00e0_0094_a400;
  localparam logic [47:0] RST_C = 48'h3b80_0000_0666;

  // writable bits; the rest keep their reset value
  localparam logic [47:0] MASK_A = 48'h9ff1_f1ff_f11f;
  localparam logic [47:0] MASK_B = 48'h7fff_ffff_ffff;
  localparam logic [47:0] MASK_C = 48'hbf8f_ffff_ffff;

  // common_config_a field positions
  localparam int unsigned POS_CHAIN_COUNT = 0;
  localparam int unsigned POS_PREDISCHARGE = 8;
  localparam int unsigned POS_POWER_SAVING = 12;
  localparam int unsigned POS_EXT_SAVING = 13;
  localparam int unsigned POS_OPEN_LOAD_RM = 15;
  localparam int unsigned POS_SCAN_COUNT = 16;
  localparam int unsigned POS_SUBPERIOD = 22;
  localparam int unsigned POS_RANGE_SEL = 28;
  localparam int unsigned POS_MULT_FACTOR = 29;
  localparam int unsigned POS_RED_DELAY = 36;
  localparam int unsigned POS_GREEN_DELAY = 39;
  localparam int unsigned POS_BLUE_DELAY = 42;
  localparam int unsigned POS_SHORT_CAT_RM = 47;

  // common_config_b field positions
  localparam int unsigned POS_SEGMENT = 0;
  localparam int unsigned POS_RED_SMOOTH = 10;
  localparam int unsigned POS_GREEN_SMOOTH = 15;
  localparam int unsigned POS_BLUE_SMOOTH = 20;
  localparam int unsigned POS_RED_BOOST = 25;
  localparam int unsigned POS_GREEN_BOOST = 29;
  localparam int unsigned POS_BLUE_BOOST = 33;
  localparam int unsigned POS_LINE_SWITCH = 37;
  localparam int unsigned POS_BLACK_ADJUST = 41;

  // decode constants; segment and line switch times in grayscale clocks
  localparam logic [9:0] SEG_CODE_LONG = 10'h3ff;
  localparam logic [10:0] SEG_CLOCKS_SHORT = 11'h080;
  localparam logic [10:0] SEG_CLOCKS_LONG = 11'h400;
  localparam logic [8:0] LINE_SW_CODE0_CLOCKS = 9'h02d;
  localparam logic [8:0] LINE_SW_STEP_CLOCKS = 9'h01e;
  localparam logic [7:0] SUBPERIOD_STEP = 8'h10;

  // extended power saving levels
  localparam logic [1:0] EXT_SAVING_OFF = 2'h0;
  localparam logic [1:0] EXT_SAVING_HIGH = 2'h1;
  localparam logic [1:0] EXT_SAVING_MID = 2'h2;
  localparam logic [1:0] EXT_SAVING_LOW = 2'h3;

endpackage : lmccr_pkg

// >>> core/lmccr_link_if.sv
/*
  Carrier between the serial link engine and the register core.
  All signals live in the serial clock domain; the core crosses them.
*/
`timescale 1ns/1ps
interface lmccr_link_if;
  logic cmd_valid;
  logic [15:0] cmd;
  logic [47:0] data;
  logic rsp_valid;
  logic [47:0] rsp_data;

  modport link (output cmd_valid, output cmd, output data,
                input rsp_valid, input rsp_data);
  modport core (input cmd_valid, input cmd, input data,
                output rsp_valid, output rsp_data);
endinterface : lmccr_link_if

// >>> core/lmccr_xfer.sv
/*
  Word crossing by toggle handshake: a source pulse flips a toggle and
  holds the word; the destination syncs the toggle in two flops and
  takes the word on its edge. Assumes pulses at least six destination
  clocks apart, which the 17-bit minimum frame guarantees.
*/
`timescale 1ns/1ps
module lmccr_xfer #(
  parameter int W = 48
) (
  // source side
  input wire logic src_clk_i,
  input wire logic src_rst_n_i,
  input wire logic src_valid_i,
  input wire logic [W-1:0] src_data_i,
  // destination side
  input wire logic dst_clk_i,
  input wire logic dst_rst_n_i,
  output logic dst_valid_o,
  output logic [W-1:0] dst_data_o
);
  typedef struct packed {
    logic tgl;
    logic [W-1:0] data;
  } lmccr_xsrc_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic valid;
    logic [W-1:0] data;
  } lmccr_xdst_t;

  lmccr_xsrc_t src_q, src_d;
  lmccr_xdst_t dst_q, dst_d;

  always_comb begin
    src_d = src_q;
    if (src_valid_i) begin
      src_d.tgl = ~src_q.tgl;
      src_d.data = src_data_i;
    end
  end

  always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
    if (!src_rst_n_i) begin
      src_q <= '0;
    end else begin
      src_q <= src_d;
    end
  end

  always_comb begin
    dst_d = dst_q;
    dst_d.s1 = src_q.tgl;
    dst_d.s2 = dst_q.s1;
    dst_d.s3 = dst_q.s2;
    dst_d.valid = dst_q.s2 ^ dst_q.s3;
    // word has been stable since the toggle flipped
    if (dst_q.s2 ^ dst_q.s3) begin
      dst_d.data = src_q.data;
    end
  end

  always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
    if (!dst_rst_n_i) begin
      dst_q <= '0;
    end else begin
      dst_q <= dst_d;
    end
  end

  assign dst_valid_o = dst_q.valid;
  assign dst_data_o = dst_q.data;
endmodule : lmccr_xfer

// >>> core/lmccr_link.sv
/*
  Serial link engine on the serial clock. Frame: start bit 1, 16-bit
  command MSB first, then 48 data bits MSB first for writes. A read is
  answered on the output line by a start bit 1 and 48 bits MSB first.
  Assumes the controller sends nothing while a read answer is pending.
*/
`timescale 1ns/1ps
module lmccr_link (
  // link clock and pins
  input wire logic serial_clk_i,
  input wire logic rst_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  // towards the core
  lmccr_link_if.link lnk
);
  typedef enum logic [4:0] {
    LK_IDLE = 5'h01,
    LK_CMD = 5'h02,
    LK_DATA = 5'h04,
    LK_WAIT = 5'h08,
    LK_SEND = 5'h10
  } lmccr_lk_st_t;

  typedef struct packed {
    lmccr_lk_st_t st;
    logic [5:0] cnt;
    logic [47:0] sh;
    logic [15:0] cmd;
    logic s1;
    logic s2;
    logic sout;
    logic cmd_valid;
  } lmccr_lk_t;

  lmccr_lk_t q, n;
  logic [15:0] cmd_word;

  always_comb begin
    n = q;
    n.s1 = serial_in_i;
    n.s2 = q.s1;
    n.cmd_valid = 1'b0;
    n.sout = 1'b0;
    cmd_word = {q.cmd[14:0], q.s2};
    unique case (q.st)
      LK_IDLE: begin
        n.cnt = '0;
        if (q.s2) begin
          n.st = LK_CMD;
        end
      end
      LK_CMD: begin
        n.cmd = cmd_word;
        n.cnt = q.cnt + 6'h01;
        if (q.cnt == 6'(lmccr_pkg::CMD_BITS - 1)) begin
          n.cnt = '0;
          n.st = LK_IDLE;
          if (cmd_word == lmccr_pkg::CMD_WR_A ||
              cmd_word == lmccr_pkg::CMD_WR_B ||
              cmd_word == lmccr_pkg::CMD_WR_C) begin
            n.st = LK_DATA;
          end else if (cmd_word == lmccr_pkg::CMD_RD_A ||
                       cmd_word == lmccr_pkg::CMD_RD_B ||
                       cmd_word == lmccr_pkg::CMD_RD_C) begin
            n.cmd_valid = 1'b1;
            n.st = LK_WAIT;
          end else if (cmd_word == lmccr_pkg::CMD_SOFT_RESET) begin
            n.cmd_valid = 1'b1;
          end
        end
      end
      LK_DATA: begin
        n.sh = {q.sh[46:0], q.s2};
        n.cnt = q.cnt + 6'h01;
        // only a whole word is handed on
        if (q.cnt == 6'(lmccr_pkg::DATA_BITS - 1)) begin
          n.cmd_valid = 1'b1;
          n.st = LK_IDLE;
        end
      end
      LK_WAIT: begin
        if (lnk.rsp_valid) begin
          n.sh = lnk.rsp_data;
          n.sout = 1'b1;
          n.cnt = '0;
          n.st = LK_SEND;
        end
      end
      LK_SEND: begin
        n.sout = q.sh[47];
        n.sh = {q.sh[46:0], 1'b0};
        n.cnt = q.cnt + 6'h01;
        if (q.cnt == 6'(lmccr_pkg::DATA_BITS - 1)) begin
          n.st = LK_IDLE;
        end
      end
      default: begin
        n.st = LK_IDLE;
      end
    endcase
  end

  always_ff @(posedge serial_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st: LK_IDLE, default: '0};
    end else begin
      q <= n;
    end
  end

  assign serial_out_o = q.sout;
  assign lnk.cmd_valid = q.cmd_valid;
  assign lnk.cmd = q.cmd;
  assign lnk.data = q.sh;
endmodule : lmccr_link

// >>> core/lmccr_regs.sv
/*
  Common configuration register bank of an LED matrix driver: three
  48-bit registers written and read over a three-wire serial link, and
  the decoded settings that steer scan, PWM and fault logic.
  Assumes a free-running serial clock and a pwm_forward_i level from
  logic on clk_i.
*/
`timescale 1ns/1ps
module lmccr_regs (
  // clocks and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serial_clk_i,
  // serial link pins
  input wire logic serial_in_i,
  output logic serial_out_o,
  // mode from PWM logic
  input wire logic pwm_forward_i,
  // decoded settings from register a
  output logic [5:0] chained_device_count_o,
  output logic predischarge_enable_o,
  output logic power_saving_enable_o,
  output logic [1:0] extended_saving_level_o,
  output logic open_load_removal_enable_o,
  output logic [6:0] scan_line_count_o,
  output logic [7:0] subperiod_count_o,
  output logic multiplier_range_select_o,
  output logic [4:0] multiplier_factor_o,
  output logic [2:0] red_group_delay_o,
  output logic [2:0] green_group_delay_o,
  output logic [2:0] blue_group_delay_o,
  output logic short_caterpillar_removal_enable_o,
  // decoded settings from register b
  output logic [10:0] segment_clock_count_o,
  output logic [5:0] red_low_gray_smoothing_o,
  output logic [5:0] green_low_gray_smoothing_o,
  output logic [5:0] blue_low_gray_smoothing_o,
  output logic [3:0] red_low_gray_boost_o,
  output logic [3:0] green_low_gray_boost_o,
  output logic [3:0] blue_low_gray_boost_o,
  output logic [8:0] line_switch_time_o,
  output logic [5:0] black_field_adjust_o,
  // register c passed on whole
  output logic [47:0] common_config_c_o
);
  typedef struct packed {
    logic [47:0] cfg_a;
    logic [47:0] cfg_b;
    logic [47:0] cfg_c;
    logic rsp_valid;
    logic [47:0] rsp_data;
    logic [5:0] dev_count;
    logic [6:0] scan_lines;
    logic [7:0] subperiods;
    logic [4:0] mult;
    logic [2:0] dly_r;
    logic [2:0] dly_g;
    logic [2:0] dly_b;
    logic [10:0] seg_clocks;
    logic [5:0] smooth_r;
    logic [5:0] smooth_g;
    logic [5:0] smooth_b;
    logic [8:0] line_sw;
  } lmccr_core_t;

  lmccr_core_t q, n;
  lmccr_link_if lnk ();

  logic c_valid;
  logic [63:0] c_word;
  logic [15:0] c_cmd;
  logic [47:0] c_data;
  logic [3:0] ls_code;

  assign c_cmd = c_word[63:48];
  assign c_data = c_word[47:0];

  lmccr_link u_link (
    .serial_clk_i(serial_clk_i),
    .rst_n_i(rst_n_i),
    .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o),
    .lnk(lnk.link)
  );

  // commands and write data into the core clock
  lmccr_xfer #(.W(64)) u_cmd_xfer (
    .src_clk_i(serial_clk_i),
    .src_rst_n_i(rst_n_i),
    .src_valid_i(lnk.cmd_valid),
    .src_data_i({lnk.cmd, lnk.data}),
    .dst_clk_i(clk_i),
    .dst_rst_n_i(rst_n_i),
    .dst_valid_o(c_valid),
    .dst_data_o(c_word)
  );

  // read answers back to the serial clock
  lmccr_xfer #(.W(48)) u_rsp_xfer (
    .src_clk_i(clk_i),
    .src_rst_n_i(rst_n_i),
    .src_valid_i(q.rsp_valid),
    .src_data_i(q.rsp_data),
    .dst_clk_i(serial_clk_i),
    .dst_rst_n_i(rst_n_i),
    .dst_valid_o(lnk.rsp_valid),
    .dst_data_o(lnk.rsp_data)
  );

  always_comb begin
    n = q;
    n.rsp_valid = 1'b0;
    ls_code = '0;
    if (c_valid) begin
      case (c_cmd)
        lmccr_pkg::CMD_WR_A: begin
          n.cfg_a = (c_data & lmccr_pkg::MASK_A) |
                    (lmccr_pkg::RST_A & ~lmccr_pkg::MASK_A);
        end
        lmccr_pkg::CMD_WR_B: begin
          n.cfg_b = (c_data & lmccr_pkg::MASK_B) |
                    (lmccr_pkg::RST_B & ~lmccr_pkg::MASK_B);
        end
        lmccr_pkg::CMD_WR_C: begin
          n.cfg_c = (c_data & lmccr_pkg::MASK_C) |
                    (lmccr_pkg::RST_C & ~lmccr_pkg::MASK_C);
        end
        lmccr_pkg::CMD_RD_A: begin
          n.rsp_valid = 1'b1;
          n.rsp_data = q.cfg_a;
        end
        lmccr_pkg::CMD_RD_B: begin
          n.rsp_valid = 1'b1;
          n.rsp_data = q.cfg_b;
        end
        lmccr_pkg::CMD_RD_C: begin
          n.rsp_valid = 1'b1;
          n.rsp_data = q.cfg_c;
        end
        lmccr_pkg::CMD_SOFT_RESET: begin
          n.cfg_a = lmccr_pkg::RST_A;
          n.cfg_b = lmccr_pkg::RST_B;
          n.cfg_c = lmccr_pkg::RST_C;
        end
        default: begin
        end
      endcase
    end
    // decoded settings follow the stored words in the same edge
    n.dev_count = 6'(n.cfg_a[lmccr_pkg::POS_CHAIN_COUNT +: 5])
                  + 6'h01;
    n.scan_lines = 7'(n.cfg_a[lmccr_pkg::POS_SCAN_COUNT +: 6])
                   + 7'h01;
    n.subperiods = (8'(n.cfg_a[lmccr_pkg::POS_SUBPERIOD +: 3]) + 8'h01)
                   * lmccr_pkg::SUBPERIOD_STEP;
    n.mult = 5'(n.cfg_a[lmccr_pkg::POS_MULT_FACTOR +: 4]) + 5'h01;
    n.dly_r = pwm_forward_i ?
              n.cfg_a[lmccr_pkg::POS_RED_DELAY +: 3] : 3'h0;
    n.dly_g = pwm_forward_i ?
              n.cfg_a[lmccr_pkg::POS_GREEN_DELAY +: 3] : 3'h0;
    n.dly_b = pwm_forward_i ?
              n.cfg_a[lmccr_pkg::POS_BLUE_DELAY +: 3] : 3'h0;
    n.seg_clocks = (n.cfg_b[lmccr_pkg::POS_SEGMENT +: 10] ==
                    lmccr_pkg::SEG_CODE_LONG) ?
                   lmccr_pkg::SEG_CLOCKS_LONG :
                   lmccr_pkg::SEG_CLOCKS_SHORT;
    n.smooth_r = 6'(n.cfg_b[lmccr_pkg::POS_RED_SMOOTH +: 5])
                 + 6'h01;
    n.smooth_g = 6'(n.cfg_b[lmccr_pkg::POS_GREEN_SMOOTH +: 5])
                 + 6'h01;
    n.smooth_b = 6'(n.cfg_b[lmccr_pkg::POS_BLUE_SMOOTH +: 5])
                 + 6'h01;
    ls_code = n.cfg_b[lmccr_pkg::POS_LINE_SWITCH +: 4];
    n.line_sw = (ls_code == 4'h0) ? lmccr_pkg::LINE_SW_CODE0_CLOCKS :
                9'((9'(ls_code) + 9'h001)
                   * lmccr_pkg::LINE_SW_STEP_CLOCKS);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{cfg_a: lmccr_pkg::RST_A, cfg_b: lmccr_pkg::RST_B,
             cfg_c: lmccr_pkg::RST_C, dev_count: 6'h08,
             scan_lines: 7'h01, subperiods: 8'h10, mult: 5'h08,
             seg_clocks: 11'h080, smooth_r: 6'h0a, smooth_g: 6'h0a,
             smooth_b: 6'h0a, line_sw: 9'h0f0, default: '0};
    end else begin
      q <= n;
    end
  end

  // enable bits and raw fields come straight from the stored words; counts, times and delays from their decoded flops
  assign chained_device_count_o = q.dev_count;
  assign predischarge_enable_o = q.cfg_a[lmccr_pkg::POS_PREDISCHARGE];
  assign power_saving_enable_o = q.cfg_a[lmccr_pkg::POS_POWER_SAVING];
  assign extended_saving_level_o =
    q.cfg_a[lmccr_pkg::POS_EXT_SAVING +: 2];
  assign open_load_removal_enable_o =
    q.cfg_a[lmccr_pkg::POS_OPEN_LOAD_RM];
  assign scan_line_count_o = q.scan_lines;
  assign subperiod_count_o = q.subperiods;
  assign multiplier_range_select_o =
    q.cfg_a[lmccr_pkg::POS_RANGE_SEL];
  assign multiplier_factor_o = q.mult;
  assign red_group_delay_o = q.dly_r;
  assign green_group_delay_o = q.dly_g;
  assign blue_group_delay_o = q.dly_b;
  assign short_caterpillar_removal_enable_o =
    q.cfg_a[lmccr_pkg::POS_SHORT_CAT_RM];
  assign segment_clock_count_o = q.seg_clocks;
  assign red_low_gray_smoothing_o = q.smooth_r;
  assign green_low_gray_smoothing_o = q.smooth_g;
  assign blue_low_gray_smoothing_o = q.smooth_b;
  assign red_low_gray_boost_o = q.cfg_b[lmccr_pkg::POS_RED_BOOST +: 4];
  assign green_low_gray_boost_o =
    q.cfg_b[lmccr_pkg::POS_GREEN_BOOST +: 4];
  assign blue_low_gray_boost_o =
    q.cfg_b[lmccr_pkg::POS_BLUE_BOOST +: 4];
  assign line_switch_time_o = q.line_sw;
  assign black_field_adjust_o =
    q.cfg_b[lmccr_pkg::POS_BLACK_ADJUST +: 6];
  assign common_config_c_o = q.cfg_c;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_wr_a;
    c_valid && c_cmd == lmccr_pkg::CMD_WR_A;
  endsequence
  sequence s_wr_b;
    c_valid && c_cmd == lmccr_pkg::CMD_WR_B;
  endsequence
  sequence s_soft;
    c_valid && c_cmd == lmccr_pkg::CMD_SOFT_RESET;
  endsequence

  property p_chain_count;
    s_wr_a |=> chained_device_count_o ==
               6'($past(c_data[4:0])) + 6'h01;
  endproperty
  a_chain_count: assert property (p_chain_count)
    else $error("chained device count wrong after write");

  property p_ps_enable;
    s_wr_a |=> power_saving_enable_o == $past(c_data[12])
               && predischarge_enable_o == $past(c_data[8]);
  endproperty
  a_ps_enable: assert property (p_ps_enable)
    else $error("enable bits do not follow write");

  property p_scan_lines;
    s_wr_a |=> scan_line_count_o == 7'($past(c_data[21:16])) + 7'h01;
  endproperty
  a_scan_lines: assert property (p_scan_lines)
    else $error("scan line count wrong after write");

  property p_mult;
    s_wr_a |=> multiplier_factor_o == 5'($past(c_data[32:29])) + 5'h01;
  endproperty
  a_mult: assert property (p_mult)
    else $error("multiplier factor wrong after write");

  property p_delay_gate;
    !pwm_forward_i |=> red_group_delay_o == 3'h0
                       && blue_group_delay_o == 3'h0;
  endproperty
  a_delay_gate: assert property (p_delay_gate)
    else $error("group delay outside forward mode");

  property p_segment;
    s_wr_b |=> segment_clock_count_o ==
               (($past(c_data[9:0]) == 10'h3ff) ? 11'h400 : 11'h080);
  endproperty
  a_segment: assert property (p_segment)
    else $error("segment clock count wrong");

  property p_line_zero;
    s_wr_b ##0 (c_data[40:37] == 4'h0) |=> line_switch_time_o == 9'h02d;
  endproperty
  a_line_zero: assert property (p_line_zero)
    else $error("line switch code zero not 45 clocks");

  property p_soft;
    s_soft |=> predischarge_enable_o && scan_line_count_o == 7'h01
               && common_config_c_o == lmccr_pkg::RST_C;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset did not restore registers");

  property p_reserved;
    s_wr_a |=> q.cfg_a[46:45] == 2'h1 && q.cfg_a[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits changed by write");

  property p_stable;
    !c_valid |=> $stable(q.cfg_a) && $stable(q.cfg_b);
  endproperty
  a_stable: assert property (p_stable)
    else $error("register changed without accepted word");

endmodule : lmccr_regs

// >>> testbench/lmccr_ctl_model.sv
/*
  Display controller model: sends link frames and collects read answers.
  Assumes the link samples serial_in on the rising serial clock edge;
  answer bits are taken mid-cycle on the falling edge.
*/
`timescale 1ns/1ps
module lmccr_ctl_model (
  // link pins
  input wire logic serial_clk_i,
  input wire logic serial_out_i,
  output logic serial_in_o
);
  initial serial_in_o = 1'b0;

  task automatic shift(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge serial_clk_i);
      serial_in_o <= v[i];
    end
  endtask : shift

  // start bit, command, data for writes, then idle low
  task automatic frame(input logic [15:0] c, input bit wr,
                       input logic [47:0] d);
    shift({47'h0, 1'b1, c}, 17);
    if (wr) shift({16'h0, d}, 48);
    @(posedge serial_clk_i);
    serial_in_o <= 1'b0;
  endtask : frame

  task automatic read(input logic [15:0] c, output logic [47:0] d,
                      output bit ok);
    ok = 1'b0;
    d = '0;
    frame(c, 1'b0, 48'h0);
    for (int i = 0; i < 64 && !ok; i++) begin
      @(negedge serial_clk_i);
      ok = (serial_out_i === 1'b1);
    end
    for (int i = 47; i >= 0 && ok; i--) begin
      @(negedge serial_clk_i);
      d[i] = serial_out_i;
    end
  endtask : read
endmodule : lmccr_ctl_model

// >>> testbench/lmccr_regs_tb.sv
/*
  Self-checking bench of the common configuration register bank.
  Assumes the controller model in lmccr_ctl_model drives the link.
*/
`timescale 1ns/1ps
module lmccr_regs_tb;
  logic clk_i, rst_n_i, serial_clk_i, serial_in_i, serial_out_o;
  logic pwm_forward_i, predischarge_enable_o, power_saving_enable_o;
  logic open_load_removal_enable_o, multiplier_range_select_o;
  logic short_caterpillar_removal_enable_o;
  logic [1:0] extended_saving_level_o;
  logic [2:0] red_group_delay_o, green_group_delay_o, blue_group_delay_o;
  logic [3:0] red_low_gray_boost_o, green_low_gray_boost_o;
  logic [3:0] blue_low_gray_boost_o;
  logic [4:0] multiplier_factor_o;
  logic [5:0] chained_device_count_o, black_field_adjust_o;
  logic [5:0] red_low_gray_smoothing_o, green_low_gray_smoothing_o;
  logic [5:0] blue_low_gray_smoothing_o;
  logic [6:0] scan_line_count_o;
  logic [7:0] subperiod_count_o;
  logic [8:0] line_switch_time_o;
  logic [10:0] segment_clock_count_o;
  logic [47:0] common_config_c_o;
  int failures, checked;

  lmccr_regs lmccr_regs_i (.clk_i, .rst_n_i, .serial_clk_i, .serial_in_i,
    .serial_out_o, .pwm_forward_i, .chained_device_count_o,
    .predischarge_enable_o, .power_saving_enable_o,
    .extended_saving_level_o, .open_load_removal_enable_o,
    .scan_line_count_o, .subperiod_count_o, .multiplier_range_select_o,
    .multiplier_factor_o, .red_group_delay_o, .green_group_delay_o,
    .blue_group_delay_o, .short_caterpillar_removal_enable_o,
    .segment_clock_count_o, .red_low_gray_smoothing_o,
    .green_low_gray_smoothing_o, .blue_low_gray_smoothing_o,
    .red_low_gray_boost_o, .green_low_gray_boost_o,
    .blue_low_gray_boost_o, .line_switch_time_o, .black_field_adjust_o,
    .common_config_c_o);

  lmccr_ctl_model lmccr_ctl_model_i (.serial_clk_i,
    .serial_out_i(serial_out_o), .serial_in_o(serial_in_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // serial clock out of phase with the core clock
  initial begin
    serial_clk_i = 1'b0;
    #2;
    forever #6 serial_clk_i = ~serial_clk_i;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // read a register back, then let the core clock settle outputs
  task automatic read_chk(input logic [15:0] c, input logic [47:0] exp);
    logic [47:0] d;
    bit ok;
    lmccr_ctl_model_i.read(c, d, ok);
    check(ok, 1'b1);
    check(d, exp);
    @(negedge clk_i);
  endtask : read_chk

  task automatic check_reset();
    read_chk(16'haa60, lmccr_pkg::RST_A);
    read_chk(16'haa61, lmccr_pkg::RST_B);
    read_chk(16'haa62, lmccr_pkg::RST_C);
    check(chained_device_count_o, 48'h8);
    check(predischarge_enable_o, 1'b1);
    check({open_load_removal_enable_o, extended_saving_level_o,
           power_saving_enable_o}, 4'h0);
    check(scan_line_count_o, 48'h1);
    check(subperiod_count_o, 48'h10);
    check(multiplier_factor_o, 48'h8);
    check(segment_clock_count_o, 48'h80);
    check(green_low_gray_smoothing_o, 48'ha);
    check(line_switch_time_o, 48'hf0);
    check(common_config_c_o, lmccr_pkg::RST_C);
  endtask : check_reset

  task automatic write_a(input logic [47:0] d, input logic fwd);
    @(posedge clk_i);
    pwm_forward_i <= fwd;
    lmccr_ctl_model_i.frame(lmccr_pkg::CMD_WR_A, 1'b1, d);
    read_chk(16'haa60, (d & lmccr_pkg::MASK_A) |
      (lmccr_pkg::RST_A & ~lmccr_pkg::MASK_A));
    check(chained_device_count_o, d[4:0] + 48'h1);
    check(predischarge_enable_o, d[8]);
    check(power_saving_enable_o, d[12]);
    check(extended_saving_level_o, d[14:13]);
    check(open_load_removal_enable_o, d[15]);
    check(scan_line_count_o, d[21:16] + 48'h1);
    check(subperiod_count_o, 48'h10 * (d[24:22] + 48'h1));
    check(multiplier_range_select_o, d[28]);
    check(multiplier_factor_o, d[32:29] + 48'h1);
    check({blue_group_delay_o, green_group_delay_o, red_group_delay_o},
      fwd ? d[44:36] : 9'h0);
    check(short_caterpillar_removal_enable_o, d[47]);
  endtask : write_a

  task automatic write_b(input logic [47:0] d);
    lmccr_ctl_model_i.frame(lmccr_pkg::CMD_WR_B, 1'b1, d);
    read_chk(16'haa61, (d & lmccr_pkg::MASK_B) |
      (lmccr_pkg::RST_B & ~lmccr_pkg::MASK_B));
    check(segment_clock_count_o,
      d[9:0] == 10'h3ff ? 48'h400 : 48'h80);
    check(red_low_gray_smoothing_o, d[14:10] + 48'h1);
    check(green_low_gray_smoothing_o, d[19:15] + 48'h1);
    check(blue_low_gray_smoothing_o, d[24:20] + 48'h1);
    check({blue_low_gray_boost_o, green_low_gray_boost_o,
           red_low_gray_boost_o}, d[36:25]);
    check(line_switch_time_o, d[40:37] == 4'h0 ? 48'h2d :
      (d[40:37] + 48'h1) * 48'h1e);
    check(black_field_adjust_o, d[46:41]);
  endtask : write_b

  task automatic write_c(input logic [47:0] d);
    logic [47:0] exp;
    exp = (d & lmccr_pkg::MASK_C) | (lmccr_pkg::RST_C & ~lmccr_pkg::MASK_C);
    lmccr_ctl_model_i.frame(lmccr_pkg::CMD_WR_C, 1'b1, d);
    read_chk(lmccr_pkg::CMD_RD_C, exp);
    check(common_config_c_o, exp);
  endtask : write_c

  // unknown command leaves the registers alone
  task automatic unknown_cmd();
    lmccr_ctl_model_i.frame(16'haa05, 1'b0, 48'h0);
    read_chk(lmccr_pkg::CMD_RD_B, (48'h1234_5678_9abc & lmccr_pkg::MASK_B) |
      (lmccr_pkg::RST_B & ~lmccr_pkg::MASK_B));
  endtask : unknown_cmd

  task automatic soft_reset();
    lmccr_ctl_model_i.frame(lmccr_pkg::CMD_SOFT_RESET, 1'b0, 48'h0);
    check_reset();
  endtask : soft_reset

  initial begin
    rst_n_i = 1'b0;
    pwm_forward_i = 1'b0;
    failures = 0;
    checked = 0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge serial_clk_i);
    check_reset();
    write_a(48'hffff_ffff_ffff, 1'b1);
    write_a(48'hffff_ffff_ffff, 1'b0);
    write_a(48'h0, 1'b1);
    write_a(48'h1234_5678_2000, 1'b1);
    write_a(48'ha5a5_5a5a_5a5a, 1'b1);
    write_b(48'hffff_ffff_ffff);
    write_b(48'h0000_0000_007f);
    write_b(48'h1234_5678_9abc);
    write_c(48'hffff_ffff_ffff);
    unknown_cmd();
    soft_reset();
    wrap_up();
  end

  initial begin
    #300000;
    failures++;
    wrap_up();
  end
endmodule : lmccr_regs_tb
